/* File: sfr_array_model.sv */
// Behavioural main array behind the read path's request port.
// Assumes one request at a time; it answers within three clocks.
`timescale 1ns/10ps
module sfr_array_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic slow,
    input wire logic mem_req_valid,
    output logic mem_req_ready,
    input wire logic [9:0] mem_page,
    input wire logic [8:0] mem_byte,
    output logic mem_rsp_valid,
    input wire logic mem_rsp_ready,
    output logic [7:0] mem_rsp_data
);
    logic busy_r;
    logic late_r;
    logic tick_r;
    logic [7:0] data_r;

    // Slow mode takes requests only every other clock and answers a clock later
    assign mem_req_ready = mem_req_valid && !busy_r && (!slow || tick_r);
    assign mem_rsp_valid = busy_r && !late_r;
    // Inverted byte between answers so a stale sample cannot pass
    assign mem_rsp_data = mem_rsp_valid ? data_r : ~data_r;

    // Contents mix byte with page bits 9-8 and 5-0; page bits 7-6 never show in the data
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            busy_r <= 1'h0;
            late_r <= 1'h0;
            tick_r <= 1'h0;
            data_r <= 8'h00;
        end else begin
            tick_r <= !tick_r;
            late_r <= 1'h0;
            if (mem_req_ready) begin
                busy_r <= 1'h1;
                late_r <= slow;
                data_r <= mem_byte[7:0] ^ {mem_page[9:8], mem_page[5:0]} ^ {mem_byte[8], 7'h00};
            end else if (mem_rsp_valid && mem_rsp_ready) begin
                busy_r <= 1'h0;
            end
        end
    end
endmodule

/* File: sfr_pkg.sv */
// Shared constants and types of the serial flash array-read path.
// Assumes the importer runs on the single system clock.
package sfr_pkg;
    // Supported read opcodes
    localparam logic [7:0] SFR_OP_LEGACY = 8'hE8;
    localparam logic [7:0] SFR_OP_FAST = 8'h0B;
    localparam logic [7:0] SFR_OP_SLOW = 8'h03;
    // Don't-care bits clocked in after the address, per opcode
    localparam logic [5:0] SFR_DUM_LEGACY = 6'h20;
    localparam logic [5:0] SFR_DUM_FAST = 6'h08;
    localparam logic [5:0] SFR_DUM_SLOW = 6'h00;
    // Last bit index of the opcode and address phases
    localparam logic [5:0] SFR_OPC_LAST = 6'h07;
    localparam logic [5:0] SFR_ADDR_LAST = 6'h17;
    // Widths
    localparam int SFR_DATA_W = 8;
    localparam int SFR_PAGE_W = 10;
    localparam int SFR_BYTE_W = 9;
    localparam int SFR_FIFO_DEPTH = 2;
    // Field positions in the right-aligned 24-bit address
    localparam int SFR_LONG_PAGE_LSB = 9;
    localparam int SFR_SHORT_PAGE_LSB = 8;
    localparam int SFR_SHORT_BYTE_W = 8;
    // Last byte of a page in each page-size setting
    localparam logic [8:0] SFR_LAST_BYTE_LONG = 9'h107;
    localparam logic [8:0] SFR_LAST_BYTE_SHORT = 9'h0FF;
    // Synchroniser lanes and their reset levels
    localparam int SFR_SYNC_N = 5;
    localparam int SFR_IX_SI = 0;
    localparam int SFR_IX_SCK = 1;
    localparam int SFR_IX_CS = 2;
    localparam int SFR_IX_PS = 3;
    localparam int SFR_IX_RSTP = 4;
    localparam logic [4:0] SFR_SYNC_RST = 5'h14;

    typedef enum logic [2:0] {
        SFR_ST_IDLE = 3'b000,
        SFR_ST_OPC = 3'b001,
        SFR_ST_ADR = 3'b011,
        SFR_ST_DUM = 3'b010,
        SFR_ST_DAT = 3'b110,
        SFR_ST_IGN = 3'b111
    } sfr_state_e;
endpackage

/* File: sfr_read_path.sv */
// SPI-slave front end and sequential main-array read path of a serial flash.
// Assumes the SPI pins are asynchronous to clk_sys and that the serial clock
// is slow enough (half period of many clk_sys cycles) to be oversampled.
// The main array itself sits outside, behind a request/response read port.
`timescale 1ns/10ps

// How it works
// - CS falling starts an opcode-then-address command.
// - Opcode, address and data travel MSB first.
// - Three address bytes with leading don't-care bits.
// - Long pages: top ten page, next nine byte.
// - Short pages: bits 17-8 page, 7-0 byte.
// - Buffer byte address nine or eight bits wide.
// - E8h takes address plus four dummy bytes.
// - Address counter advances by itself while streaming.
// - 0Bh takes address plus one dummy byte.
// - 03h streams data right after the address.
// - Page end rolls into next page, no gap.
// - Array end wraps to first page, no gap.
// - CS rising ends read, output released.
// - Array reads never touch the SRAM buffer; here each read loads buf_byte_addr.
// - Works with clock idle low or high.
// - Sample on rising clock, shift out on falling.
// - CS high ignores input, output released.
// - Reset pin low aborts and holds idle.
module sfr_read_path (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic page_size_264,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_si,
    output logic spi_so_o,
    output logic spi_so_oe,
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    output logic [sfr_pkg::SFR_PAGE_W-1:0] mem_page,
    output logic [sfr_pkg::SFR_BYTE_W-1:0] mem_byte,
    input wire logic mem_rsp_valid,
    output logic mem_rsp_ready,
    input wire logic [sfr_pkg::SFR_DATA_W-1:0] mem_rsp_data,
    output logic [sfr_pkg::SFR_BYTE_W-1:0] buf_byte_addr,
    output logic streaming
);
    import sfr_pkg::*;

    // Pin synchronisers
    logic [SFR_SYNC_N-1:0] pins_in, sync1_r, sync2_r;
    logic sck_d_r;
    logic si_s, sck_s, cs_s, ps_s, rstp_s, rise, fall, abort;

    // Command and fetch state
    sfr_state_e st_r, st_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [22:0] sr_r, sr_nxt;
    logic [5:0] dum_r, dum_nxt;
    logic ps_r, ps_nxt;
    logic [SFR_PAGE_W-1:0] page_r, page_nxt;
    logic [SFR_BYTE_W-1:0] byte_r, byte_nxt;
    logic [SFR_BYTE_W-1:0] buf_r, buf_nxt;
    logic fetch_r, fetch_nxt;
    logic req_r, req_nxt;
    logic out_r, out_nxt;
    logic disc_r, disc_nxt;
    logic [23:0] addr_full;
    logic [7:0] opc_full;
    logic [SFR_BYTE_W-1:0] last_byte;

    // Output shifter state
    logic [SFR_DATA_W-1:0] shift_r, shift_nxt;
    logic [2:0] obit_r, obit_nxt;
    logic oe_r, oe_nxt;

    // Buffer wiring
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, pop;
    logic [SFR_DATA_W-1:0] fifo_out_data;

    assign pins_in = {reset_pin_n, page_size_264, spi_cs_n, spi_sck, spi_si};

    // Two flops per pin before any logic looks at it
    genvar g;
    generate
        for (g = 0; g < SFR_SYNC_N; g++) begin : g_sync
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    sync1_r[g] <= SFR_SYNC_RST[g];
                    sync2_r[g] <= SFR_SYNC_RST[g];
                end else begin
                    sync1_r[g] <= pins_in[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    // Edge history of the serial clock, taken from the second stage only
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
        end
    end

    assign si_s = sync2_r[SFR_IX_SI];
    assign sck_s = sync2_r[SFR_IX_SCK];
    assign cs_s = sync2_r[SFR_IX_CS];
    assign ps_s = sync2_r[SFR_IX_PS];
    assign rstp_s = sync2_r[SFR_IX_RSTP];
    // Only edges matter, so either clock idle level works
    assign rise = sck_s && !sck_d_r;
    assign fall = !sck_s && sck_d_r;
    assign abort = cs_s || !rstp_s;

    assign addr_full = {sr_r, si_s};
    assign opc_full = {sr_r[6:0], si_s};
    assign last_byte = ps_r ? SFR_LAST_BYTE_LONG : SFR_LAST_BYTE_SHORT;

    // Command decode, address counter and array fetch control
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sr_nxt = sr_r;
        dum_nxt = dum_r;
        ps_nxt = ps_r;
        page_nxt = page_r;
        byte_nxt = byte_r;
        buf_nxt = buf_r;
        fetch_nxt = fetch_r;
        req_nxt = req_r;
        out_nxt = out_r;
        disc_nxt = disc_r;
        // Accepted request: step to the next byte, rolling over pages
        if (req_r && mem_req_ready) begin
            req_nxt = 1'b0;
            if (byte_r >= last_byte) begin
                byte_nxt = '0;
                page_nxt = page_r + SFR_PAGE_W'(1);
            end else begin
                byte_nxt = byte_r + SFR_BYTE_W'(1);
            end
        end
        if (mem_rsp_valid && mem_rsp_ready) begin
            out_nxt = 1'b0;
            disc_nxt = 1'b0;
        end
        // One read in flight at a time; buffer space gates the next one
        if (fetch_r && !out_r && fifo_in_ready) begin
            req_nxt = 1'b1;
            out_nxt = 1'b1;
        end
        case (st_r)
            SFR_ST_IDLE: begin
                if (!cs_s) begin
                    st_nxt = SFR_ST_OPC;
                    cnt_nxt = '0;
                    ps_nxt = ps_s;
                end
            end
            SFR_ST_OPC: begin
                if (rise) begin
                    sr_nxt = {sr_r[21:0], si_s};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == SFR_OPC_LAST) begin
                        cnt_nxt = '0;
                        st_nxt = SFR_ST_ADR;
                        case (opc_full)
                            SFR_OP_LEGACY: dum_nxt = SFR_DUM_LEGACY;
                            SFR_OP_FAST: dum_nxt = SFR_DUM_FAST;
                            SFR_OP_SLOW: dum_nxt = SFR_DUM_SLOW;
                            default: st_nxt = SFR_ST_IGN;
                        endcase
                    end
                end
            end
            SFR_ST_ADR: begin
                if (rise) begin
                    sr_nxt = {sr_r[21:0], si_s};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == SFR_ADDR_LAST) begin
                        cnt_nxt = '0;
                        // Leading bits above the split are simply dropped
                        if (ps_r) begin
                            page_nxt = addr_full[SFR_LONG_PAGE_LSB +: SFR_PAGE_W];
                            byte_nxt = addr_full[SFR_BYTE_W-1:0];
                            buf_nxt = addr_full[SFR_BYTE_W-1:0];
                        end else begin
                            page_nxt = addr_full[SFR_SHORT_PAGE_LSB +: SFR_PAGE_W];
                            byte_nxt = {1'b0, addr_full[SFR_SHORT_BYTE_W-1:0]};
                            buf_nxt = {1'b0, addr_full[SFR_SHORT_BYTE_W-1:0]};
                        end
                        // Prefetch starts now so dummy-less reads are ready in time
                        fetch_nxt = 1'b1;
                        st_nxt = (dum_r == SFR_DUM_SLOW) ? SFR_ST_DAT : SFR_ST_DUM;
                    end
                end
            end
            SFR_ST_DUM: begin
                if (rise) begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == dum_r - 6'h01) begin
                        st_nxt = SFR_ST_DAT;
                    end
                end
            end
            SFR_ST_DAT: begin
                st_nxt = SFR_ST_DAT; // Streams until CS rises
            end
            SFR_ST_IGN: begin
                st_nxt = SFR_ST_IGN; // Unsupported opcode: wait out the frame
            end
            default: begin
                st_nxt = SFR_ST_IDLE;
            end
        endcase
        // Deselect or reset pin ends the command and fetching; a request already raised still goes out, and late answers are dropped
        if (abort) begin
            st_nxt = SFR_ST_IDLE;
            fetch_nxt = 1'b0;
            disc_nxt = out_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r <= SFR_ST_IDLE;
            cnt_r <= '0;
            sr_r <= '0;
            dum_r <= '0;
            ps_r <= 1'b0;
            page_r <= '0;
            byte_r <= '0;
            buf_r <= '0;
            fetch_r <= 1'b0;
            req_r <= 1'b0;
            out_r <= 1'b0;
            disc_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sr_r <= sr_nxt;
            dum_r <= dum_nxt;
            ps_r <= ps_nxt;
            page_r <= page_nxt;
            byte_r <= byte_nxt;
            buf_r <= buf_nxt;
            fetch_r <= fetch_nxt;
            req_r <= req_nxt;
            out_r <= out_nxt;
            disc_r <= disc_nxt;
        end
    end

    // Output shifter: a new byte is taken on the falling edge at bit 0
    assign pop = (st_r == SFR_ST_DAT) && fall && (obit_r == 3'h0);

    always_comb begin
        shift_nxt = shift_r;
        obit_nxt = obit_r;
        oe_nxt = (st_r == SFR_ST_DAT) && !abort;
        if (st_r != SFR_ST_DAT) begin
            obit_nxt = 3'h0;
        end else if (fall) begin
            // An empty buffer repeats stale data; the clock was too fast
            if (obit_r == 3'h0) begin
                shift_nxt = fifo_out_data;
            end else begin
                shift_nxt = {shift_r[SFR_DATA_W-2:0], 1'b0};
            end
            obit_nxt = obit_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            shift_r <= '0;
            obit_r <= 3'h0;
            oe_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            obit_r <= obit_nxt;
            oe_r <= oe_nxt;
        end
    end

    // Stale answers after an abort are taken and thrown away
    assign fifo_in_valid = mem_rsp_valid && !disc_r;
    assign mem_rsp_ready = disc_r || fifo_in_ready;

    sfr_skid_fifo #(
        .WIDTH(SFR_DATA_W),
        .DEPTH(SFR_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .flush(abort),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(mem_rsp_data),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    assign spi_so_o = shift_r[SFR_DATA_W-1];
    assign spi_so_oe = oe_r;
    assign mem_req_valid = req_r;
    assign mem_page = page_r;
    assign mem_byte = byte_r;
    assign buf_byte_addr = buf_r;
    assign streaming = (st_r == SFR_ST_DAT) && fifo_out_valid;
endmodule

/* File: sfr_read_path_properties.sv */
// Port checker of the serial flash array-read path.
// Assumes it is bound onto sfr_read_path and runs on clk_sys only.
`timescale 1ns/10ps
module sfr_read_path_checker
    import sfr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic page_size_264,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_so_o,
    input wire logic spi_so_oe,
    input wire logic mem_req_valid,
    input wire logic mem_req_ready,
    input wire logic [9:0] mem_page,
    input wire logic [8:0] mem_byte,
    input wire logic streaming
);
    logic [8:0] last_byte;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // Last byte of a page; a start beyond it also rolls on
    assign last_byte = page_size_264 ? SFR_LAST_BYTE_LONG : SFR_LAST_BYTE_SHORT;

    // Array handshake steps; the take is gated on pins so a late abort is not judged
    sequence s_take;
        mem_req_valid && mem_req_ready && !spi_cs_n && reset_pin_n;
    endsequence
    sequence s_wait;
        mem_req_valid && !mem_req_ready;
    endsequence

    property p_req_hold;
        s_wait |=> mem_req_valid && $stable(mem_page) && $stable(mem_byte);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved while waiting");
    property p_one_out;
        s_take |=> !mem_req_valid;
    endproperty
    a_one_out: assert property (p_one_out) else $error("second request too early");
    property p_step;
        s_take ##0 (mem_byte < last_byte) |=> mem_byte == $past(mem_byte) + 9'h001
            && $stable(mem_page);
    endproperty
    a_step: assert property (p_step) else $error("byte counter did not step");
    property p_roll;
        s_take ##0 (mem_byte >= last_byte) |=> mem_byte == 9'h000
            && mem_page == $past(mem_page) + 10'h001;
    endproperty
    a_roll: assert property (p_roll) else $error("page did not roll over");
    property p_short_byte;
        mem_req_valid && !spi_cs_n && !page_size_264 |-> !mem_byte[8];
    endproperty
    a_short_byte: assert property (p_short_byte) else $error("byte bit 8 set");
    property p_cs_idle;
        spi_cs_n [*5] |-> !spi_so_oe && !streaming;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("output driven while deselected");
    property p_cs_end;
        $rose(spi_cs_n) |-> ##[1:5] !spi_so_oe;
    endproperty
    a_cs_end: assert property (p_cs_end) else $error("output not released");
    property p_so_fall;
        spi_so_oe && $past(spi_so_oe) && $changed(spi_so_o) |-> !spi_sck && !$past(spi_sck, 2);
    endproperty
    a_so_fall: assert property (p_so_fall) else $error("output moved off falling clock");
    property p_oe_start;
        $rose(spi_so_oe) |-> !spi_cs_n && reset_pin_n;
    endproperty
    a_oe_start: assert property (p_oe_start) else $error("output enabled outside read");
    property p_pin_hold;
        !reset_pin_n [*4] |-> !spi_so_oe && !streaming;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("busy during reset pin");
endmodule

bind sfr_read_path sfr_read_path_checker sfr_read_path_checker_i (
    .clk_sys, .reset, .reset_pin_n, .page_size_264, .spi_cs_n, .spi_sck, .spi_so_o,
    .spi_so_oe, .mem_req_valid, .mem_req_ready, .mem_page, .mem_byte, .streaming
);

/* File: sfr_skid_fifo.sv */
// Two-entry byte buffer between the array read port and the output shifter.
// Assumes one clock; flush empties it at once and wins over a push.
`timescale 1ns/10ps
module sfr_skid_fifo #(
    parameter int WIDTH = sfr_pkg::SFR_DATA_W,
    parameter int DEPTH = sfr_pkg::SFR_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import sfr_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != PW'(0) + (PW+1)'(DEPTH)) ;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and storage update; pointers wrap at the depth
    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
        end
        if (pop) begin
            rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
        end
        cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        if (flush) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

/* File: tb_sfr_read_path.sv */
// Self-checking bench of the serial flash array-read path.
// Assumes the array model and the bound checker are compiled before it.
`timescale 1ns/10ps
module tb_sfr_read_path;
    import sfr_pkg::*;
    localparam int HALF = 10;
    localparam int LIMIT = 60000;
    localparam logic [7:0] OPS [4] = '{SFR_OP_LEGACY, SFR_OP_FAST, SFR_OP_SLOW, 8'hA5};
    localparam logic [5:0] DUMS [4] = '{SFR_DUM_LEGACY, SFR_DUM_FAST, SFR_DUM_SLOW, 6'h00};
    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic reset_pin_n = 1'h1;
    logic page_size_264 = 1'h0;
    logic spi_cs_n = 1'h1;
    logic spi_sck = 1'h0;
    logic spi_si = 1'h0;
    logic slow = 1'h0;
    logic spi_so_o, spi_so_oe, mem_req_valid, mem_req_ready, mem_rsp_valid, mem_rsp_ready;
    logic streaming;
    logic [9:0] mem_page;
    logic [8:0] mem_byte;
    logic [8:0] buf_byte_addr;
    logic [7:0] mem_rsp_data;
    logic [31:0] rnd = 32'hD9FC;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;

    // Clock at 40 MHz
    always #12.5 clk_sys = ~clk_sys;

    sfr_read_path sfr_read_path_i (.clk_sys, .reset, .reset_pin_n, .page_size_264, .spi_cs_n,
        .spi_sck, .spi_si, .spi_so_o, .spi_so_oe, .mem_req_valid, .mem_req_ready, .mem_page,
        .mem_byte, .mem_rsp_valid, .mem_rsp_ready, .mem_rsp_data, .buf_byte_addr, .streaming);
    sfr_array_model sfr_array_model_i (.clk_sys, .reset, .slow, .mem_req_valid, .mem_req_ready,
        .mem_page, .mem_byte, .mem_rsp_valid, .mem_rsp_ready, .mem_rsp_data);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected array contents, worked out independently of the design
    function automatic logic [7:0] exp_byte(input logic [9:0] pg, input logic [8:0] by);
        return by[7:0] ^ {pg[9:8], pg[5:0]} ^ {by[8], 7'h00};
    endfunction

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One serial clock period; output is taken late in the high phase, well settled
    task automatic sbit(input logic b, output logic r);
        @(posedge clk_sys);
        spi_sck <= 1'h0;
        spi_si <= b;
        repeat (HALF) @(posedge clk_sys);
        spi_sck <= 1'h1;
        repeat (HALF) @(posedge clk_sys);
        @(negedge clk_sys);
        r = spi_so_oe ? spi_so_o : 1'hZ;
    endtask

    // Whole read frame: opcode, address, dummy bits, then nb bytes compared
    task automatic frame(input int k, input logic [23:0] adr, input logic ps, input logic m3,
        input int nb, input logic abort);
        logic [9:0] pg;
        logic [8:0] by;
        logic [7:0] got;
        logic [31:0] word;
        logic r;
        pg = ps ? adr[18:9] : adr[17:8];
        by = ps ? adr[8:0] : {1'h0, adr[7:0]};
        word = {OPS[k], adr};
        @(posedge clk_sys);
        rnd = lfsr(rnd);
        slow <= rnd[5];
        page_size_264 <= ps;
        spi_sck <= m3;
        repeat (20) @(posedge clk_sys);
        spi_cs_n <= 1'h0;
        for (int i = 31; i >= 0; i--) begin
            sbit(word[i], r);
        end
        for (int i = 0; i < int'(DUMS[k]); i++) begin
            rnd = lfsr(rnd);
            sbit(rnd[0], r);
        end
        for (int n = 0; n < nb; n++) begin
            for (int i = 7; i >= 0; i--) begin
                sbit(rnd[i], r);
                got[i] = r;
            end
            check("data byte", {1'h0, got}, k < 3 ? {1'h0, exp_byte(pg, by)} : 9'h0ZZ);
            if (by >= (ps ? SFR_LAST_BYTE_LONG : SFR_LAST_BYTE_SHORT)) begin
                by = 9'h000;
                pg = pg + 10'h001;
            end else begin
                by = by + 9'h001;
            end
        end
        // Mid-stream the buffer is refilled and the pin driven, unless the opcode was refused
        check("streaming flag", {8'h00, streaming}, (k < 3) ? 9'h001 : 9'h000);
        check("output enable in data", {8'h00, spi_so_oe}, (k < 3) ? 9'h001 : 9'h000);
        if (k < 3) begin
            check("buffer byte address", buf_byte_addr, ps ? adr[8:0] : {1'h0, adr[7:0]});
        end
        @(posedge clk_sys);
        if (abort) begin
            reset_pin_n <= 1'h0;
            repeat (6) @(posedge clk_sys);
            @(negedge clk_sys);
            check("output enable at reset pin", {8'h00, spi_so_oe}, 9'h000);
            @(posedge clk_sys);
        end
        spi_sck <= m3;
        repeat (HALF) @(posedge clk_sys);
        spi_cs_n <= 1'h1;
        reset_pin_n <= 1'h1;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        check("output enable after frame", {8'h00, spi_so_oe}, 9'h000);
    endtask

    // Cycle ceiling cuts a hung run short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'h0;
        // Page end, array end and a start past the page end, both page sizes
        frame(2, 24'hFF00FE, 1'h0, 1'h0, 3, 1'h0);
        frame(1, 24'h03FFFE, 1'h0, 1'h1, 3, 1'h0);
        frame(0, 24'hF7FF06, 1'h1, 1'h0, 3, 1'h0);
        frame(2, 24'h00012C, 1'h1, 1'h1, 2, 1'h0);
        // Unknown opcode leaves the output released; reset pin aborts a read
        frame(3, 24'h000000, 1'h0, 1'h0, 1, 1'h0);
        frame(1, 24'h000010, 1'h1, 1'h0, 1, 1'h1);
        // Random reads over opcodes, clock modes, page sizes and array speeds
        for (int j = 0; j < 9; j++) begin
            rnd = lfsr(rnd);
            // Legacy opcode kept rare, as hosts are steered to the other two reads
            frame((j % 4 == 3) ? 0 : 1 + (j % 2), rnd[31:8], rnd[0], rnd[1], 2,
                1'h0);
        end
        final_report();
    end
endmodule
